// ==== src/drc_relay_reset.sv ====
// Purpose: Relay status outputs with delays, setting storage and trip recovery control.
// Assumes: drive_status and trip come from logic on mclk; reset pins are asynchronous.
// Notes:   Wishbone classic slave, one wait state; out-of-range writes are ignored.
`timescale 1ns/1ps

// Summary of operation
// - Each relay selects one of 32 conditions.
// - Relay follows its selected condition.
// - Code 29 uses control word bits 11/12.
// - Bus timeout releases serially driven relays.
// - Relay A switch-on delayed 0-600 seconds.
// - Relay A switch-off delayed 0-600 seconds.
// - Pulse reference full-scale, two input ranges.
// - Pulse feedback full-scale 100-65000 Hz.
// - Bus output percentages hidden from panel.
// - Pulse output full-scale frequency setting.
// - Recovery mode decodes attempt counts.
// - Manual mode clears trip only by reset.
// - Automatic modes reset until attempts exhausted.
// - Attempts spaced by restart interval.
// - Restart interval 0-1800 seconds, default 10.
module drc_relay_reset
    import drc_pkg::*;
#(
    parameter int SEC_CYCLES = CYC_PER_SEC
) (
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // Wishbone classic slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Local operator panel read port.
    input  wire logic [5:0]  panel_addr,
    output logic      [31:0] panel_rdata,
    // Drive state.
    input  wire logic [31:0] drive_status,
    input  wire logic        bus_timeout,
    input  wire logic        trip,
    input  wire logic        run_stable,
    input  wire logic        reset_key,
    input  wire logic        reset_din,
    // Outputs.
    output logic             relay_a,
    output logic             relay_b,
    output logic             fault_clear,
    output logic      [16:0] pulse_ref_full_scale_fast,
    output logic      [16:0] pulse_ref_full_scale_slow,
    output logic      [16:0] pulse_feedback_full_scale,
    output logic      [16:0] pulse_output_scaling,
    output logic      [16:0] bus_out_a,
    output logic      [16:0] bus_out_b
);

    if (SEC_CYCLES < 2 || SEC_CYCLES > 67108863) begin : g_chk
        $error("SEC_CYCLES out of range");
    end

    localparam logic [25:0] SEC_LAST = 26'(SEC_CYCLES - 1);

    // Settings.
    drc_relay_sel_t relay_sel_q;
    logic [16:0]    cut_in_q, cut_out_q, restart_interval_q;
    logic [3:0]     trip_recovery_mode_q;
    logic [15:0]    ctrl_word_q;
    logic           ack_q;
    logic [31:0]    rdata_q, prdata_q, bus_rd, panel_rd, wr_val;
    // Timers, relays and recovery state.
    logic [25:0]    rly_cyc_q, rst_cyc_q;
    logic [16:0]    rly_sec_q, rst_sec_q;
    logic           relay_a_q, relay_b_q, fault_clear_q, trip_prev_q, timeout_prev_q;
    logic [4:0]     attempts_q, attempt_limit;
    logic           unlimited, exhausted;
    drc_state_t     state_q;
    logic [1:0]     key_sync_q, din_sync_q;
    logic           man_prev_q;
    logic           cond_a, cond_b, pending_a, man_reset_ev, trip_ev, wr_en;
    logic [16:0]    delay_a;

    // Pick one condition; code 29 takes the serial control word instead.
    function automatic logic pick(input logic [4:0] sel, input logic ctrl_bit, input logic tmo,
                                  input logic [31:0] st);
        if (sel == FN_CTRL_WORD) begin
            pick = ctrl_bit & ~tmo;
        end else if (sel == FN_NONE) begin
            pick = 1'b0;
        end else begin
            pick = st[sel];
        end
    endfunction

    // Register read mux; hide zeroes the bus-only output values.
    function automatic logic [31:0] rd(input logic [5:0] a, input logic hide);
        rd = 32'h0000_0000;
        case (a)
            OFS_RELAY_SEL:   rd = {19'h0_0000, relay_sel_q.sel_b, 3'h0, relay_sel_q.sel_a};
            OFS_CUT_IN:      rd = {15'h0000, cut_in_q};
            OFS_CUT_OUT:     rd = {15'h0000, cut_out_q};
            OFS_PREF_FAST:   rd = {15'h0000, pulse_ref_full_scale_fast};
            OFS_PREF_SLOW:   rd = {15'h0000, pulse_ref_full_scale_slow};
            OFS_PFB_FS:      rd = {15'h0000, pulse_feedback_full_scale};
            OFS_BUS_OUT_A:   rd = hide ? 32'h0000_0000 : {15'h0000, bus_out_a};
            OFS_BUS_OUT_B:   rd = hide ? 32'h0000_0000 : {15'h0000, bus_out_b};
            OFS_POUT_SCALE:  rd = {15'h0000, pulse_output_scaling};
            OFS_RECOV_MODE:  rd = {28'h000_0000, trip_recovery_mode_q};
            OFS_RESTART_INT: rd = {15'h0000, restart_interval_q};
            OFS_CTRL_WORD:   rd = {16'h0000, ctrl_word_q};
            OFS_STATUS:      rd = {19'h0_0000, attempts_q, 2'(state_q), 3'h0, exhausted, relay_b_q, relay_a_q};
            default:         rd = 32'h0000_0000;
        endcase
    endfunction

    // Byte-lane merge of the write data into the addressed register.
    always_comb begin
        wr_val = bus_rd;
        for (int i = 0; i < 4; i++) begin
            if (wb_sel_i[i]) begin
                wr_val[i*8 +: 8] = wb_dat_i[i*8 +: 8];
            end
        end
    end

    // Both read views come from one decoder so they cannot drift apart.
    always_comb begin
        bus_rd   = rd(wb_adr_i, 1'b0);
        panel_rd = rd(panel_addr, 1'b1);
    end

    assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q;

    // Bus handshake: ack one cycle after the request, dropped the cycle after.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ack_q    <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            prdata_q <= 32'h0000_0000;
        end else begin
            ack_q    <= wb_cyc_i & wb_stb_i & ~ack_q;
            rdata_q  <= bus_rd;
            prdata_q <= panel_rd;
        end
    end

    // Settings registers; a write outside the legal range keeps the old value.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            relay_sel_q.sel_a         <= FN_ALARM;
            relay_sel_q.sel_b         <= FN_RUNNING;
            cut_in_q                  <= DELAY_RST;
            cut_out_q                 <= DELAY_RST;
            pulse_ref_full_scale_fast <= PREF_RST;
            pulse_ref_full_scale_slow <= PREF_RST;
            pulse_feedback_full_scale <= PFB_RST;
            bus_out_a                 <= 17'h00000;
            bus_out_b                 <= 17'h00000;
            pulse_output_scaling      <= POUT_RST;
            trip_recovery_mode_q      <= MODE_MANUAL;
            restart_interval_q        <= RESTART_RST;
        end else if (wr_en) begin
            case (wb_adr_i)
                OFS_RELAY_SEL: begin
                    relay_sel_q.sel_a <= wr_val[SEL_A_LSB +: 5];
                    relay_sel_q.sel_b <= wr_val[SEL_B_LSB +: 5];
                end
                OFS_CUT_IN:      if (wr_val[16:0] <= DELAY_MAX && wr_val[31:17] == 15'h0000)
                                     cut_in_q <= wr_val[16:0];
                OFS_CUT_OUT:     if (wr_val[16:0] <= DELAY_MAX && wr_val[31:17] == 15'h0000)
                                     cut_out_q <= wr_val[16:0];
                OFS_PREF_FAST:   if (wr_val[16:0] >= PFREQ_MIN && wr_val[16:0] <= PFREQ_FAST_MX && wr_val[31:17] == 15'h0000)
                                     pulse_ref_full_scale_fast <= wr_val[16:0];
                OFS_PREF_SLOW:   if (wr_val[16:0] >= PFREQ_MIN && wr_val[16:0] <= PFREQ_SLOW_MX && wr_val[31:17] == 15'h0000)
                                     pulse_ref_full_scale_slow <= wr_val[16:0];
                OFS_PFB_FS:      if (wr_val[16:0] >= PFREQ_MIN && wr_val[16:0] <= PFREQ_FAST_MX && wr_val[31:17] == 15'h0000)
                                     pulse_feedback_full_scale <= wr_val[16:0];
                OFS_BUS_OUT_A:   if (wr_val[16:0] <= BUS_OUT_MAX && wr_val[31:17] == 15'h0000)
                                     bus_out_a <= wr_val[16:0];
                OFS_BUS_OUT_B:   if (wr_val[16:0] <= BUS_OUT_MAX && wr_val[31:17] == 15'h0000)
                                     bus_out_b <= wr_val[16:0];
                OFS_POUT_SCALE:  if (wr_val[16:0] >= POUT_MIN && wr_val[16:0] <= POUT_MAX && wr_val[31:17] == 15'h0000)
                                     pulse_output_scaling <= wr_val[16:0];
                OFS_RECOV_MODE:  if (wr_val[3:0] <= MODE_MAX && wr_val[31:4] == 28'h000_0000)
                                     trip_recovery_mode_q <= wr_val[3:0];
                OFS_RESTART_INT: if (wr_val[16:0] <= RESTART_MAX && wr_val[31:17] == 15'h0000)
                                     restart_interval_q <= wr_val[16:0];
                default: ;
            endcase
        end
    end

    // Control word; the timeout edge wipes the relay bits so they stay off afterwards.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_word_q    <= 16'h0000;
            timeout_prev_q <= 1'b0;
        end else begin
            timeout_prev_q <= bus_timeout;
            if (bus_timeout && !timeout_prev_q) begin
                ctrl_word_q[CTRL_RELAY_A] <= 1'b0;
                ctrl_word_q[CTRL_RELAY_B] <= 1'b0;
            end else if (wr_en && wb_adr_i == OFS_CTRL_WORD) begin
                ctrl_word_q <= wr_val[15:0];
            end
        end
    end

    // Condition selection for both relays.
    always_comb begin
        cond_a    = pick(relay_sel_q.sel_a, ctrl_word_q[CTRL_RELAY_A], bus_timeout, drive_status);
        cond_b    = pick(relay_sel_q.sel_b, ctrl_word_q[CTRL_RELAY_B], bus_timeout, drive_status);
        pending_a = cond_a != relay_a_q;
        delay_a   = cond_a ? cut_in_q : cut_out_q;
    end

    // Relay A delay timer restarts whenever no change is pending.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rly_cyc_q <= 26'h000_0000;
            rly_sec_q <= 17'h00000;
        end else if (!pending_a) begin
            rly_cyc_q <= 26'h000_0000;
            rly_sec_q <= 17'h00000;
        end else if (rly_cyc_q == SEC_LAST) begin
            rly_cyc_q <= 26'h000_0000;
            rly_sec_q <= rly_sec_q + 17'h00001;
        end else begin
            rly_cyc_q <= rly_cyc_q + 26'h000_0001;
        end
    end

    // Relay contacts; a timeout release of a serial relay skips the off delay.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            relay_a_q <= 1'b0;
            relay_b_q <= 1'b0;
        end else begin
            relay_b_q <= cond_b;
            if (bus_timeout && relay_sel_q.sel_a == FN_CTRL_WORD) begin
                relay_a_q <= 1'b0;
            end else if (pending_a && rly_sec_q >= delay_a) begin
                relay_a_q <= cond_a;
            end
        end
    end

    // Manual reset pins are asynchronous, so each passes two flip-flops first.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            key_sync_q <= 2'b00;
            din_sync_q <= 2'b00;
            man_prev_q <= 1'b0;
            trip_prev_q <= 1'b0;
        end else begin
            key_sync_q  <= {key_sync_q[0], reset_key};
            din_sync_q  <= {din_sync_q[0], reset_din};
            man_prev_q  <= key_sync_q[1] | din_sync_q[1];
            trip_prev_q <= trip;
        end
    end

    assign man_reset_ev = (key_sync_q[1] | din_sync_q[1]) & ~man_prev_q;
    assign trip_ev      = trip & ~trip_prev_q;

    // Attempt budget for the selected recovery mode.
    always_comb begin
        unlimited = trip_recovery_mode_q == MODE_INFINITE;
        case (trip_recovery_mode_q)
            4'h6:    attempt_limit = 5'h0a;
            4'h7:    attempt_limit = 5'h0f;
            4'h8:    attempt_limit = 5'h14;
            4'h9:    attempt_limit = 5'h00;
            default: attempt_limit = {1'b0, trip_recovery_mode_q};
        endcase
        exhausted = !unlimited && attempts_q >= attempt_limit;
    end

    // Restart interval timer runs only while waiting for an automatic reset.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_cyc_q <= 26'h000_0000;
            rst_sec_q <= 17'h00000;
        end else if (state_q != ST_WAIT) begin
            rst_cyc_q <= 26'h000_0000;
            rst_sec_q <= 17'h00000;
        end else if (rst_cyc_q == SEC_LAST) begin
            rst_cyc_q <= 26'h000_0000;
            rst_sec_q <= rst_sec_q + 17'h00001;
        end else begin
            rst_cyc_q <= rst_cyc_q + 26'h000_0001;
        end
    end

    // Trip recovery; a manual reset is honoured in any tripped state.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_q       <= ST_RUN;
            attempts_q    <= 5'h00;
            fault_clear_q <= 1'b0;
        end else begin
            fault_clear_q <= 1'b0;
            case (state_q)
                ST_RUN: begin
                    if (trip_ev) begin
                        state_q <= exhausted ? ST_HOLD : ST_WAIT;
                    end else if (run_stable) begin
                        attempts_q <= 5'h00;
                    end
                end
                ST_WAIT: begin
                    if (man_reset_ev) begin
                        fault_clear_q <= 1'b1;
                        attempts_q    <= 5'h00;
                        state_q       <= ST_RUN;
                    end else if (rst_sec_q >= restart_interval_q) begin
                        fault_clear_q <= 1'b1;
                        if (!unlimited) begin
                            attempts_q <= attempts_q + 5'h01;
                        end
                        state_q <= ST_RUN;
                    end
                end
                ST_HOLD: begin
                    if (man_reset_ev) begin
                        fault_clear_q <= 1'b1;
                        attempts_q    <= 5'h00;
                        state_q       <= ST_RUN;
                    end
                end
                default: state_q <= ST_RUN;
            endcase
        end
    end

    assign wb_ack_o    = ack_q;
    assign wb_dat_o    = rdata_q;
    assign panel_rdata = prdata_q;
    assign relay_a     = relay_a_q;
    assign relay_b     = relay_b_q;
    assign fault_clear = fault_clear_q;

    // Checks on relay, setting range and trip recovery behaviour.
    property p_relay_b_follow;
        @(posedge mclk) disable iff (!arst_n)
        (relay_sel_q.sel_b == FN_RUNNING && drive_status[3]) |=> relay_b;
    endproperty
    a_relay_b_follow: assert property (p_relay_b_follow) else $error("Relay B missed its condition.");

    property p_ctrl_bit;
        @(posedge mclk) disable iff (!arst_n)
        (relay_sel_q.sel_b == FN_CTRL_WORD && ctrl_word_q[CTRL_RELAY_B] && !bus_timeout) |=> relay_b;
    endproperty
    a_ctrl_bit: assert property (p_ctrl_bit) else $error("Control bit 12 did not drive relay B.");

    property p_timeout_cut;
        @(posedge mclk) disable iff (!arst_n)
        (bus_timeout && relay_sel_q.sel_a == FN_CTRL_WORD) |=> !relay_a;
    endproperty
    a_timeout_cut: assert property (p_timeout_cut) else $error("Bus timeout did not release relay A.");

    property p_cut_in_zero;
        @(posedge mclk) disable iff (!arst_n)
        (!relay_a_q && cond_a && cut_in_q == 17'h00000) |=> relay_a;
    endproperty
    a_cut_in_zero: assert property (p_cut_in_zero) else $error("Relay A did not close at once.");

    property p_cut_in_hold;
        @(posedge mclk) disable iff (!arst_n)
        (!relay_a_q && cond_a && cut_in_q != 17'h00000 && rly_sec_q == 17'h00000) |=> !relay_a;
    endproperty
    a_cut_in_hold: assert property (p_cut_in_hold) else $error("Relay A closed before its delay.");

    property p_cut_out_hold;
        @(posedge mclk) disable iff (!arst_n)
        (relay_a_q && !cond_a && !bus_timeout && cut_out_q != 17'h00000 && rly_sec_q == 17'h00000) |=> relay_a;
    endproperty
    a_cut_out_hold: assert property (p_cut_out_hold) else $error("Relay A opened before its delay.");

    property p_cancel;
        @(posedge mclk) disable iff (!arst_n)
        (!relay_a_q && cond_a && cut_in_q != 17'h00000 && rly_sec_q == 17'h00000) ##1 !cond_a |=>
            !relay_a ##1 rly_sec_q == 17'h00000;
    endproperty
    a_cancel: assert property (p_cancel) else $error("Cancelled delay changed relay A.");

    property p_ranges;
        @(posedge mclk) disable iff (!arst_n)
        pulse_feedback_full_scale >= PFREQ_MIN && pulse_ref_full_scale_slow <= PFREQ_SLOW_MX && bus_out_a <= BUS_OUT_MAX;
    endproperty
    a_ranges: assert property (p_ranges) else $error("A setting left its legal range.");

    property p_manual_hold;
        @(posedge mclk) disable iff (!arst_n)
        (state_q == ST_RUN && trip_ev && trip_recovery_mode_q == MODE_MANUAL) |=>
            state_q == ST_HOLD ##1 (!fault_clear || $past(man_reset_ev));
    endproperty
    a_manual_hold: assert property (p_manual_hold) else $error("Manual mode did not hold the trip.");

    property p_auto_clear;
        @(posedge mclk) disable iff (!arst_n)
        (state_q == ST_WAIT && !man_reset_ev && rst_sec_q >= restart_interval_q) |=> fault_clear && state_q == ST_RUN;
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("Automatic reset missed its interval.");

    property p_wait_early;
        @(posedge mclk) disable iff (!arst_n)
        (state_q == ST_WAIT && !man_reset_ev && rst_sec_q < restart_interval_q) |=> !fault_clear;
    endproperty
    a_wait_early: assert property (p_wait_early) else $error("Automatic reset came too early.");

    property p_exhausted;
        @(posedge mclk) disable iff (!arst_n)
        (state_q == ST_RUN && trip_ev && exhausted) |=> state_q == ST_HOLD;
    endproperty
    a_exhausted: assert property (p_exhausted) else $error("Exhausted attempts did not wait for manual reset.");

    c_relay_a_delayed: cover property (@(posedge mclk) disable iff (!arst_n) $rose(relay_a) && cut_in_q != 17'h00000);
    c_auto_reset:      cover property (@(posedge mclk) disable iff (!arst_n) state_q == ST_WAIT ##1 fault_clear);
    c_manual_reset:    cover property (@(posedge mclk) disable iff (!arst_n) state_q == ST_HOLD ##1 state_q == ST_RUN);
    c_timeout_cut:     cover property (@(posedge mclk) disable iff (!arst_n) relay_b ##1 $rose(bus_timeout) ##1 !relay_b);

endmodule // drc_relay_reset

// ==== src/drc_pkg.sv ====
// Purpose: Shared constants and types of the relay and trip-recovery control block.
// Assumes: One 50 MHz control clock; registers are 32-bit Wishbone words.
// Notes:   All setting limits, defaults and register offsets live here, except the zero resets of bus_out_a, bus_out_b and the control word.
package drc_pkg;

    // Clock and time base.
    localparam int CLK_FREQ_HZ  = 50_000_000;
    localparam int SECOND_S     = 1;
    localparam int CYC_PER_SEC  = SECOND_S * CLK_FREQ_HZ;

    // Register byte offsets.
    localparam logic [5:0] OFS_RELAY_SEL   = 6'h00;
    localparam logic [5:0] OFS_CUT_IN      = 6'h04;
    localparam logic [5:0] OFS_CUT_OUT     = 6'h08;
    localparam logic [5:0] OFS_PREF_FAST   = 6'h0c;
    localparam logic [5:0] OFS_PREF_SLOW   = 6'h10;
    localparam logic [5:0] OFS_PFB_FS      = 6'h14;
    localparam logic [5:0] OFS_BUS_OUT_A   = 6'h18;
    localparam logic [5:0] OFS_BUS_OUT_B   = 6'h1c;
    localparam logic [5:0] OFS_POUT_SCALE  = 6'h20;
    localparam logic [5:0] OFS_RECOV_MODE  = 6'h24;
    localparam logic [5:0] OFS_RESTART_INT = 6'h28;
    localparam logic [5:0] OFS_CTRL_WORD   = 6'h2c;
    localparam logic [5:0] OFS_STATUS      = 6'h30;

    // Field positions.
    localparam int SEL_A_LSB      = 0;
    localparam int SEL_B_LSB      = 8;
    localparam int CTRL_RELAY_A   = 11;
    localparam int CTRL_RELAY_B   = 12;

    // Function codes.
    localparam logic [4:0] FN_NONE      = 5'h00;
    localparam logic [4:0] FN_RUNNING   = 5'h03;
    localparam logic [4:0] FN_ALARM     = 5'h08;
    localparam logic [4:0] FN_CTRL_WORD = 5'h1d;

    // Setting limits and reset values.
    localparam logic [16:0] DELAY_MAX     = 17'h00258;
    localparam logic [16:0] DELAY_RST     = 17'h00000;
    localparam logic [16:0] PFREQ_MIN     = 17'h00064;
    localparam logic [16:0] PFREQ_FAST_MX = 17'h0fde8;
    localparam logic [16:0] PFREQ_SLOW_MX = 17'h01388;
    localparam logic [16:0] PREF_RST      = 17'h01388;
    localparam logic [16:0] PFB_RST       = 17'h061a8;
    localparam logic [16:0] BUS_OUT_MAX   = 17'h003e8;
    localparam logic [16:0] POUT_MIN      = 17'h00001;
    localparam logic [16:0] POUT_MAX      = 17'h07d00;
    localparam logic [16:0] POUT_RST      = 17'h01388;
    localparam logic [16:0] RESTART_MAX   = 17'h00708;
    localparam logic [16:0] RESTART_RST   = 17'h0000a;
    localparam logic [3:0]  MODE_MANUAL   = 4'h0;
    localparam logic [3:0]  MODE_MAX      = 4'h9;
    localparam logic [3:0]  MODE_INFINITE = 4'h9;

    // Relay function selectors travel together.
    typedef struct packed {
        logic [4:0] sel_b;
        logic [4:0] sel_a;
    } drc_relay_sel_t;

    // Trip recovery states.
    typedef enum logic [1:0] {
        ST_RUN,
        ST_WAIT,
        ST_HOLD
    } drc_state_t;

endpackage

// ==== test/drc_drive_model.sv ====
// Purpose: Drive side model that trips on request and clears on the fault clear pulse.
// Assumes: Everything runs on mclk.
// Notes:   A trip holds until cleared, so a missed clear shows up as a stuck trip.
`timescale 1ns/1ps
module drc_drive_model (
    // Clock and reset.
    input  wire logic mclk,
    input  wire logic arst_n,
    // Trip request and clear.
    input  wire logic trip_req,
    input  wire logic fault_clear,
    output logic      trip
);
    // The clear wins over a new request, as a real drive acknowledges its reset first.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) trip <= 1'b0;
        else if (fault_clear) trip <= 1'b0;
        else if (trip_req) trip <= 1'b1;
    end
endmodule // drc_drive_model

// ==== test/drive_relay_and_reset_control_tb.sv ====
// Purpose: Self-checking bench for relay outputs, settings and trip recovery.
// Assumes: One second is shortened to 10 cycles.
// Notes:   Byte lanes and reset_din are tied.
`timescale 1ns/1ps
module drive_relay_and_reset_control_tb;
    import drc_pkg::*;
    logic        mclk, arst_n, cyc, we, ack, bto, trq, rkey, ra, rb, fc, trip, rs;
    logic [5:0]  adr, padr;
    logic [31:0] wd, rd, prd, ds, got;
    int          err_total, checks_done, cc, n;
    drc_relay_reset #(.SEC_CYCLES(10)) i_dut (.mclk(mclk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
        .panel_addr(padr), .panel_rdata(prd), .drive_status(ds), .bus_timeout(bto), .trip(trip),
        .run_stable(rs), .reset_key(rkey), .reset_din(1'b0), .relay_a(ra), .relay_b(rb),
        .fault_clear(fc), .pulse_ref_full_scale_fast(), .pulse_ref_full_scale_slow(),
        .pulse_feedback_full_scale(), .pulse_output_scaling(), .bus_out_a(), .bus_out_b());
    drc_drive_model i_drv (.mclk(mclk), .arst_n(arst_n), .trip_req(trq), .fault_clear(fc), .trip(trip));
    // Report, verdict and end of run.
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Compare and count; an unknown never matches.
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // One classic cycle; read data is taken at the edge where ack is seen.
    task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        we  <= w;
        adr <= a;
        wd  <= d;
        @(posedge mclk);
        while (ack !== 1'b1) @(posedge mclk);
        got = rd;
        cyc <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rdc(input logic [5:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(got, e);
    endtask
    // Counts edges until a signal shows a level, giving up at the limit.
    task automatic wait_lvl(ref logic s, input logic v, input int lim);
        n = 0;
        while (s !== v && n < lim) begin
            @(posedge mclk);
            n++;
        end
    endtask
    task automatic trip_now();
        trq <= 1'b1;
        @(posedge mclk);
        trq <= 1'b0;
    endtask
    // Clock and hang guard.
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cc++;
        if (cc == 3000) begin
            err_total++;
            finish_test();
        end
    end
    // Main sequence.
    initial begin
        {cyc, we, bto, trq, rkey, rs, adr, padr, wd, ds} = '0;
        arst_n = 1'b0;
        repeat (10) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        rdc(OFS_RELAY_SEL, 32'h308);
        rdc(OFS_PFB_FS, 32'h61a8);
        rdc(OFS_RESTART_INT, 32'ha);
        wb(1'b1, OFS_PREF_SLOW, 32'h1389);
        rdc(OFS_PREF_SLOW, 32'h1388);
        wb(1'b1, OFS_PREF_FAST, 32'hfde8);
        rdc(OFS_PREF_FAST, 32'hfde8);
        wb(1'b1, OFS_POUT_SCALE, 32'h7d01);
        rdc(OFS_POUT_SCALE, 32'h1388);
        rdc(6'h3c, 32'h0);
        // Relay B on its condition, then on the control word, then cut by the timeout.
        ds[3] <= 1'b1;
        repeat (2) @(posedge mclk);
        chk(32'(rb), 32'h1);
        wb(1'b1, OFS_RELAY_SEL, 32'h1d1d);
        wb(1'b1, OFS_CTRL_WORD, 32'h1800);
        chk(32'(rb), 32'h1);
        chk(32'(ra), 32'h1);
        bto <= 1'b1;
        repeat (2) @(posedge mclk);
        chk(32'(rb), 32'h0);
        chk(32'(ra), 32'h0);
        rdc(OFS_CTRL_WORD, 32'h0);
        bto <= 1'b0;
        wb(1'b1, OFS_RELAY_SEL, 32'h1d08);
        // Relay A delays of one second, with a short dip that must be ignored.
        wb(1'b1, OFS_CUT_IN, 32'h1);
        wb(1'b1, OFS_CUT_OUT, 32'h1);
        ds[8] <= 1'b1;
        @(posedge mclk);
        ds[8] <= 1'b0;
        repeat (14) @(posedge mclk);
        chk(32'(ra), 32'h0);
        ds[8] <= 1'b1;
        wait_lvl(ra, 1'b1, 40);
        chk(32'(n >= 9 && n <= 13), 32'h1);
        ds[8] <= 1'b0;
        repeat (5) @(posedge mclk);
        ds[8] <= 1'b1;
        repeat (15) @(posedge mclk);
        chk(32'(ra), 32'h1);
        ds[8] <= 1'b0;
        wait_lvl(ra, 1'b0, 40);
        chk(32'(n >= 9 && n <= 13), 32'h1);
        // Bus output value is kept but reads zero on the panel.
        wb(1'b1, OFS_BUS_OUT_A, 32'h3e8);
        rdc(OFS_BUS_OUT_A, 32'h3e8);
        padr <= OFS_BUS_OUT_A;
        repeat (3) @(posedge mclk);
        chk(prd, 32'h0);
        // Manual mode holds until the key; then one automatic attempt, renewed by a good run.
        trip_now();
        wait_lvl(fc, 1'b1, 30);
        chk(32'(n), 32'd30);
        rkey <= 1'b1;
        wait_lvl(fc, 1'b1, 8);
        chk(32'(n < 8), 32'h1);
        rkey <= 1'b0;
        wb(1'b1, OFS_RECOV_MODE, 32'h1);
        wb(1'b1, OFS_RECOV_MODE, 32'ha);
        rdc(OFS_RECOV_MODE, 32'h1);
        wb(1'b1, OFS_RESTART_INT, 32'h1);
        trip_now();
        wait_lvl(fc, 1'b1, 40);
        chk(32'(n >= 9 && n <= 16), 32'h1);
        rs <= 1'b1;
        @(posedge mclk);
        rs <= 1'b0;
        trip_now();
        wait_lvl(fc, 1'b1, 40);
        chk(32'(n >= 9 && n <= 16), 32'h1);
        trip_now();
        wait_lvl(fc, 1'b1, 30);
        chk(32'(n), 32'd30);
        rkey <= 1'b1;
        wait_lvl(fc, 1'b1, 8);
        chk(32'(n < 8), 32'h1);
        rkey <= 1'b0;
        finish_test();
    end
endmodule // drive_relay_and_reset_control_tb
